//--- rtl/pirc_pkg.sv
// Purpose: shared constants and state types for the priority interrupt controller
// Assumes: one clock (MCLK, 200 MHz) at both ends
// Notes:   command and status encodings are local to this block
package pirc_pkg;

    // ----------------------------------------------------------------
    // sizes and command word fields
    // ----------------------------------------------------------------
    localparam int unsigned NUM_REQ  = 8;
    localparam int unsigned CFG_BIT  = 4;
    localparam int unsigned EOI_BIT  = 5;
    localparam int unsigned BUF_BIT  = 3;
    localparam int unsigned RSEL_LSB = 0;

    localparam logic [1:0] RSEL_REQ  = 2'h0;
    localparam logic [1:0] RSEL_ISR  = 2'h1;
    localparam logic [1:0] RSEL_STAT = 2'h2;

    // status word bit positions
    localparam int unsigned ST_MASTER = 7;
    localparam int unsigned ST_BUF    = 6;
    localparam int unsigned ST_INT    = 5;

    // ----------------------------------------------------------------
    // values after reset
    // ----------------------------------------------------------------
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [1:0] RSEL_RST = 2'h0;
    // vector base, arbitrary value; low three bits carry the request id
    localparam logic [7:0] VEC_BASE = 8'h40;
    localparam logic [3:0] NO_LEVEL = 4'h8;
    localparam logic [2:0] SPUR_ID  = 3'h7;

    // ----------------------------------------------------------------
    // host strobe timing
    // ----------------------------------------------------------------
    // strobe spans the device's two-stage synchroniser with room to spare
    localparam logic [3:0]  SETUP_CYC   = 4'h2;
    localparam logic [3:0]  STROBE_CYC  = 4'h8;

    localparam logic [1:0] OP_WRITE = 2'h0;
    localparam logic [1:0] OP_READ  = 2'h1;
    localparam logic [1:0] OP_ACK   = 2'h2;

    // ----------------------------------------------------------------
    // state types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       cs_n;
        logic       rd_n;
        logic       wr_n;
        logic       ack_n;
        logic       sel;
        logic       mso;
        logic [7:0] req;
        logic [7:0] data;
    } pirc_pins_type;

    typedef struct packed {
        pirc_pins_type s1;
        pirc_pins_type s2;
        logic          wr_prev;
        logic          ack_prev;
        logic [7:0]    mask;
        logic [7:0]    isr;
        logic          buffered;
        logic [1:0]    rsel;
        logic          master;
        logic          irq;
        logic [7:0]    vec;
        logic [7:0]    dout;
        logic          doe_n;
        logic          mso_out;
        logic          mso_oe_n;
    } pirc_dev_state_type;

    typedef enum logic [1:0] {H_IDLE, H_SETUP, H_STROBE, H_HOLD} pirc_hst_type;

    typedef struct packed {
        pirc_hst_type st;
        logic [3:0]   cnt;
        logic [1:0]   op;
        logic         cs_n;
        logic         rd_n;
        logic         wr_n;
        logic         ack_n;
        logic         sel;
        logic [7:0]   dout;
        logic         doe_n;
        logic [7:0]   req;
        logic         mso_out;
        logic         mso_oe_n;
        logic         busy;
        logic         done;
        logic [7:0]   rdata;
        logic         irq;
    } pirc_host_state_type;

endpackage

//--- rtl/pirc_if.sv
// Purpose: pin-level link between processor side and interrupt controller
// Assumes: both ends clocked by the same MCLK
// Notes:   shared lines are resolved from the enables; idle lines pull high
`timescale 1ns/1ps
`default_nettype none
interface pirc_if;
    logic       cs_n;
    logic       rd_n;
    logic       wr_n;
    logic       ack_strobe_n;
    logic       port_select;
    logic [7:0] request_lines;
    logic       irq;
    logic [7:0] dev_data;
    logic       dev_data_oe_n;
    logic [7:0] host_data;
    logic       host_data_oe_n;
    logic [7:0] data_lines;
    logic       dev_mso;
    logic       dev_mso_oe_n;
    logic       host_mso;
    logic       host_mso_oe_n;
    logic       master_select_or_buffer_enable;

    // ----------------------------------------------------------------
    // wire resolution
    // ----------------------------------------------------------------
    assign data_lines = !dev_data_oe_n ? dev_data : (!host_data_oe_n ? host_data : 8'hff);
    assign master_select_or_buffer_enable = !dev_mso_oe_n ? dev_mso : (!host_mso_oe_n ? host_mso : 1'b1);

    modport dev (
        input  cs_n, rd_n, wr_n, ack_strobe_n, port_select, request_lines,
        input  data_lines, master_select_or_buffer_enable,
        output irq, dev_data, dev_data_oe_n, dev_mso, dev_mso_oe_n
    );
    modport host (
        output cs_n, rd_n, wr_n, ack_strobe_n, port_select, request_lines,
        output host_data, host_data_oe_n, host_mso, host_mso_oe_n,
        input  irq, data_lines
    );
endinterface
`default_nettype wire

//--- rtl/pirc_dev.sv
// Purpose: eight-input priority interrupt controller, device end
// Assumes: all link pins are asynchronous and pass two flip-flops
// Notes:   request 0 is highest priority; level-sensitive requests
`timescale 1ns/1ps
`default_nettype none
module pirc_dev (
    input  wire logic       MCLK,
    input  wire logic       NRST,
    pirc_if.dev             LINK,
    output var  logic       IS_MASTER,
    output var  logic       BUFFERED,
    output var  logic [7:0] IN_SERVICE
);
    import pirc_pkg::*;

    pirc_dev_state_type q;
    pirc_dev_state_type d;
    logic [7:0]         pend;
    logic               win_ok;
    logic [3:0]         win_idx;
    logic [3:0]         srv_idx;
    logic               qualify;
    logic               wr_edge;
    logic               ack_edge;
    logic               rd_act;
    logic               ack_act;
    logic [7:0]         isr_clr;
    logic [7:0]         rd_word;
    logic [7:0]         vec_now;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        d = q;
        // pins are asynchronous; only stage two is read by logic
        d.s1.cs_n  = LINK.cs_n;
        d.s1.rd_n  = LINK.rd_n;
        d.s1.wr_n  = LINK.wr_n;
        d.s1.ack_n = LINK.ack_strobe_n;
        d.s1.sel   = LINK.port_select;
        d.s1.mso   = LINK.master_select_or_buffer_enable;
        d.s1.req   = LINK.request_lines;
        d.s1.data  = LINK.data_lines;
        d.s2       = q.s1;
        d.wr_prev  = q.s2.wr_n;
        d.ack_prev = q.s2.ack_n;

        // ------------------------------------------------------------
        // priority resolution
        // ------------------------------------------------------------
        // lower index wins; NO_LEVEL loses to every real request
        pend = q.s2.req & ~q.mask;
        win_ok  = 1'b0;
        win_idx = NO_LEVEL;
        srv_idx = NO_LEVEL;
        for (int i = int'(NUM_REQ) - 1; i >= 0; i--) begin
            if (pend[i]) begin
                win_ok  = 1'b1;
                win_idx = 4'(i);
            end
            if (q.isr[i]) begin
                srv_idx = 4'(i);
            end
        end
        qualify = win_ok && (win_idx < srv_idx);

        // ------------------------------------------------------------
        // strobe decode
        // ------------------------------------------------------------
        // read and write need chip select; acknowledge needs none
        wr_edge  = q.wr_prev && !q.s2.wr_n && !q.s2.cs_n;
        ack_edge = q.ack_prev && !q.s2.ack_n;
        rd_act   = !q.s2.cs_n && !q.s2.rd_n;
        ack_act  = !q.s2.ack_n;

        // ------------------------------------------------------------
        // command capture
        // ------------------------------------------------------------
        // hazard: data and select must settle before the synced strobe falls
        isr_clr = 8'h00;
        if (wr_edge) begin
            if (q.s2.sel) begin
                d.mask = q.s2.data;
            end else begin
                if (q.s2.data[CFG_BIT]) begin
                    d.buffered = q.s2.data[BUF_BIT];
                    d.rsel     = q.s2.data[RSEL_LSB +: 2];
                end
                if (q.s2.data[EOI_BIT] && (srv_idx != NO_LEVEL)) begin
                    isr_clr[srv_idx[2:0]] = 1'b1;
                end
            end
        end

        // ------------------------------------------------------------
        // acknowledge
        // ------------------------------------------------------------
        // latch vector and mark level in service
        vec_now = q.vec;
        if (ack_edge) begin
            if (qualify) begin
                vec_now = VEC_BASE | {5'h00, win_idx[2:0]};
            end else begin
                // nothing qualifies any more: answer with highest id
                vec_now = VEC_BASE | {5'h00, SPUR_ID};
            end
        end
        d.vec = vec_now;
        // clear first so a same-cycle acknowledge keeps its bit
        d.isr = q.isr & ~isr_clr;
        if (ack_edge && qualify) begin
            d.isr[win_idx[2:0]] = 1'b1;
        end

        d.irq = qualify;

        // ------------------------------------------------------------
        // read word selection
        // ------------------------------------------------------------
        if (q.s2.sel) begin
            rd_word = q.mask;
        end else begin
            unique case (q.rsel)
                RSEL_REQ: rd_word = q.s2.req;
                RSEL_ISR: rd_word = q.isr;
                RSEL_STAT: begin
                    rd_word            = 8'h00;
                    rd_word[ST_MASTER] = q.master;
                    rd_word[ST_BUF]    = q.buffered;
                    rd_word[ST_INT]    = q.irq;
                end
                default: rd_word = 8'h00;
            endcase
        end

        // ------------------------------------------------------------
        // bus drive
        // ------------------------------------------------------------
        // acknowledge takes precedence over a read
        if (ack_act) begin
            d.dout = vec_now;
        end else begin
            d.dout = rd_word;
        end
        d.doe_n = !(ack_act || rd_act);

        // ------------------------------------------------------------
        // dual-role pin
        // ------------------------------------------------------------
        // enable follows the data drive so buffers turn with the bus
        d.mso_oe_n = !d.buffered;
        d.mso_out  = d.doe_n;
        if (!q.buffered) begin
            d.master = q.s2.mso;
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            // pins reset to their idle level so no false edge follows reset
            q          <= '0;
            q.s1       <= '1;
            q.s2       <= '1;
            q.s1.req   <= 8'h00;
            q.s2.req   <= 8'h00;
            q.wr_prev  <= 1'b1;
            q.ack_prev <= 1'b1;
            q.mask     <= MASK_RST;
            q.rsel     <= RSEL_RST;
            q.dout     <= 8'h00;
            q.doe_n    <= 1'b1;
            q.mso_out  <= 1'b1;
            q.mso_oe_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign LINK.irq           = q.irq;
    assign LINK.dev_data      = q.dout;
    assign LINK.dev_data_oe_n = q.doe_n;
    assign LINK.dev_mso       = q.mso_out;
    assign LINK.dev_mso_oe_n  = q.mso_oe_n;
    assign IS_MASTER          = q.master;
    assign BUFFERED           = q.buffered;
    assign IN_SERVICE         = q.isr;

endmodule
`default_nettype wire

//--- rtl/pirc_host.sv
// Purpose: processor-side end: strobes the controller and drives requests
// Assumes: one request at a time; BUSY high refuses new ones
// Notes:   strobe length covers the device's two-stage pin synchroniser
`timescale 1ns/1ps
`default_nettype none
module pirc_host (
    input  wire logic       MCLK,
    input  wire logic       NRST,
    pirc_if.host            LINK,
    input  wire logic       REQ,
    input  wire logic [1:0] REQ_OP,
    input  wire logic       REQ_SEL,
    input  wire logic [7:0] REQ_WDATA,
    input  wire logic [7:0] PERIPH_REQ,
    input  wire logic       STRAP_DRIVE,
    input  wire logic       STRAP_MASTER,
    output var  logic       BUSY,
    output var  logic       DONE,
    output var  logic [7:0] RDATA,
    output var  logic       IRQ
);
    import pirc_pkg::*;

    pirc_host_state_type q;
    pirc_host_state_type d;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        d          = q;
        d.done     = 1'b0;
        d.req      = PERIPH_REQ;
        d.irq      = LINK.irq;
        d.mso_out  = STRAP_MASTER;
        d.mso_oe_n = !STRAP_DRIVE;
        unique case (q.st)
            H_IDLE: begin
                if (REQ) begin
                    d.st    = H_SETUP;
                    d.busy  = 1'b1;
                    d.op    = REQ_OP;
                    d.sel   = REQ_SEL;
                    d.dout  = REQ_WDATA;
                    d.doe_n = (REQ_OP != OP_WRITE);
                    d.cs_n  = (REQ_OP == OP_ACK);
                    d.cnt   = SETUP_CYC;
                end
            end
            H_SETUP: begin
                d.cnt = q.cnt - 4'h1;
                if (q.cnt == 4'h1) begin
                    d.st  = H_STROBE;
                    d.cnt = STROBE_CYC;
                    d.wr_n  = (q.op != OP_WRITE);
                    d.rd_n  = (q.op != OP_READ);
                    d.ack_n = (q.op != OP_ACK);
                end
            end
            H_STROBE: begin
                d.cnt = q.cnt - 4'h1;
                if (q.cnt == 4'h1) begin
                    d.st    = H_HOLD;
                    d.rdata = LINK.data_lines;
                    d.wr_n  = 1'b1;
                    d.rd_n  = 1'b1;
                    d.ack_n = 1'b1;
                    d.cnt   = SETUP_CYC;
                end
            end
            H_HOLD: begin
                d.cnt = q.cnt - 4'h1;
                if (q.cnt == 4'h1) begin
                    d.st    = H_IDLE;
                    d.cs_n  = 1'b1;
                    d.doe_n = 1'b1;
                    d.busy  = 1'b0;
                    d.done  = 1'b1;
                end
            end
        endcase
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            q          <= '0;
            q.st       <= H_IDLE;
            q.cs_n     <= 1'b1;
            q.rd_n     <= 1'b1;
            q.wr_n     <= 1'b1;
            q.ack_n    <= 1'b1;
            q.doe_n    <= 1'b1;
            q.mso_out  <= 1'b1;
            q.mso_oe_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign LINK.cs_n           = q.cs_n;
    assign LINK.rd_n           = q.rd_n;
    assign LINK.wr_n           = q.wr_n;
    assign LINK.ack_strobe_n   = q.ack_n;
    assign LINK.port_select    = q.sel;
    assign LINK.request_lines  = q.req;
    assign LINK.host_data      = q.dout;
    assign LINK.host_data_oe_n = q.doe_n;
    assign LINK.host_mso       = q.mso_out;
    assign LINK.host_mso_oe_n  = q.mso_oe_n;
    assign BUSY                = q.busy;
    assign DONE                = q.done;
    assign RDATA               = q.rdata;
    assign IRQ                 = q.irq;

endmodule
`default_nettype wire

//--- tb/pirc_properties.sv
// Purpose: wire-level checks between processor side and controller
// Assumes: one clock; pins pass a two-stage synchroniser in the device
// Notes:   windows are widened by one edge either side of the sync delay
`timescale 1ns/1ps
`default_nettype none
module pirc_properties (
    input wire logic       MCLK,
    input wire logic       NRST,
    input wire logic       cs_n,
    input wire logic       rd_n,
    input wire logic       ack_strobe_n,
    input wire logic [7:0] request_lines,
    input wire logic       irq,
    input wire logic [7:0] dev_data,
    input wire logic       dev_data_oe_n,
    input wire logic       host_data_oe_n,
    input wire logic       dev_mso,
    input wire logic       dev_mso_oe_n
);
    import pirc_pkg::*;

    // ----------------------------------------------------------------
    // strobe sequences
    // ----------------------------------------------------------------
    sequence s_read_start;
        $fell(rd_n) && !cs_n;
    endsequence
    sequence s_ack_start;
        $fell(ack_strobe_n);
    endsequence
    sequence s_strobes_off;
        ((rd_n || cs_n) && ack_strobe_n) [*5];
    endsequence

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!NRST);

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_read_drives_bus: assert property (s_read_start |-> ##[2:4] !dev_data_oe_n)
        else $error("read strobe did not drive the bus");
    a_ack_drives_bus: assert property (s_ack_start |-> ##[2:4] !dev_data_oe_n)
        else $error("acknowledge did not drive the bus");
    a_idle_bus_free: assert property (s_strobes_off |-> dev_data_oe_n)
        else $error("bus driven without a selected read or acknowledge");
    a_drive_has_cause: assert property ($fell(dev_data_oe_n) |->
            ((!$past(cs_n, 3) && !$past(rd_n, 3)) || !$past(ack_strobe_n, 3)))
        else $error("bus drive began without a cause");
    a_no_bus_fight: assert property (!host_data_oe_n |-> dev_data_oe_n)
        else $error("both ends drive the data lines");
    a_vector_base: assert property (!dev_data_oe_n && !ack_strobe_n && rd_n |->
            dev_data[7:3] == VEC_BASE[7:3])
        else $error("vector outside the base block");
    a_irq_has_req: assert property (irq |->
            ($past(request_lines, 3) != 8'h00 || $past(request_lines, 4) != 8'h00))
        else $error("interrupt raised with no request");
    a_ack_drops_irq: assert property (s_ack_start ##0 irq |-> ##[2:5] !irq)
        else $error("interrupt stayed up after acknowledge");
    a_buffer_enable: assert property (!dev_mso_oe_n |->
            (dev_mso == dev_data_oe_n || dev_mso == $past(dev_data_oe_n)))
        else $error("buffer enable does not follow bus drive");
endmodule
`default_nettype wire

//--- tb/priority_interrupt_controller_test.sv
// Purpose: self-checking bench joining both ends of the controller link
// Assumes: host end is the only requester on the main link
// Notes:   a second link is driven by hand to break the select rule
`timescale 1ns/1ps
`default_nettype none
module priority_interrupt_controller_test;
    import pirc_pkg::*;
    logic       mclk = 1'b0;
    logic       nrst = 1'b0;
    logic       req = 1'b0;
    logic [1:0] req_op = 2'h0;
    logic       req_sel = 1'b0;
    logic [7:0] req_wdata = 8'h00;
    logic [7:0] periph_req = 8'h00;
    logic       strap_drive = 1'b1;
    logic       strap_master = 1'b1;
    logic       done;
    logic       busy;
    logic       host_irq;
    logic [7:0] rdata;
    logic       is_master;
    logic       buffered;
    logic [7:0] in_service;
    int         n_fail = 0;
    int         num_checks = 0;
    int         cycles = 0;

    pirc_if u_pirc_if ();
    pirc_if u_bad_if ();
    pirc_host u_pirc_host (.MCLK(mclk), .NRST(nrst), .LINK(u_pirc_if.host), .REQ(req), .REQ_OP(req_op),
        .REQ_SEL(req_sel), .REQ_WDATA(req_wdata), .PERIPH_REQ(periph_req), .STRAP_DRIVE(strap_drive),
        .STRAP_MASTER(strap_master), .BUSY(busy), .DONE(done), .RDATA(rdata), .IRQ(host_irq));
    pirc_dev u_pirc_dev (.MCLK(mclk), .NRST(nrst), .LINK(u_pirc_if.dev), .IS_MASTER(is_master),
        .BUFFERED(buffered), .IN_SERVICE(in_service));
    // second device end faces a hand driver that misuses the strobes
    pirc_dev u_pirc_dev_bad (.MCLK(mclk), .NRST(nrst), .LINK(u_bad_if.dev), .IS_MASTER(),
        .BUFFERED(), .IN_SERVICE());
    pirc_properties u_pirc_properties (.MCLK(mclk), .NRST(nrst), .cs_n(u_pirc_if.cs_n),
        .rd_n(u_pirc_if.rd_n), .ack_strobe_n(u_pirc_if.ack_strobe_n), .request_lines(u_pirc_if.request_lines),
        .irq(u_pirc_if.irq), .dev_data(u_pirc_if.dev_data), .dev_data_oe_n(u_pirc_if.dev_data_oe_n),
        .host_data_oe_n(u_pirc_if.host_data_oe_n), .dev_mso(u_pirc_if.dev_mso),
        .dev_mso_oe_n(u_pirc_if.dev_mso_oe_n));

    always #2.5 mclk = ~mclk;

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic wrap_up();
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", name, exp, got);
            n_fail++;
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic host_op(input logic [1:0] op, input logic sel, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge mclk);
        req <= 1'b1;
        req_op <= op;
        req_sel <= sel;
        req_wdata <= wd;
        @(posedge mclk);
        req <= 1'b0;
        #1;
        chk("host busy", 8'h01, {7'h00, busy});
        do begin
            @(posedge mclk);
            #1;
            n++;
        end while (done !== 1'b1 && n < 40);
        chk("host done", 8'h01, {7'h00, done});
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset_values();
        host_op(OP_READ, 1'b0, 8'h00);
        chk("request read", 8'h00, rdata);
        host_op(OP_READ, 1'b1, 8'h00);
        chk("mask after reset", MASK_RST, rdata);
        chk("in service after reset", 8'h00, in_service);
    endtask

    task automatic t_priority();
        host_op(OP_WRITE, 1'b1, 8'h08);
        @(posedge mclk);
        periph_req <= 8'h28;
        settle(8);
        chk("irq masked pick", 8'h01, {7'h00, u_pirc_if.irq});
        chk("host irq copy", 8'h01, {7'h00, host_irq});
        host_op(OP_ACK, 1'b0, 8'h00);
        chk("vector bit5", 8'h45, rdata);
        chk("in service bit5", 8'h20, in_service);
        settle(6);
        chk("irq after ack", 8'h00, {7'h00, u_pirc_if.irq});
        host_op(OP_WRITE, 1'b0, 8'h11);
        host_op(OP_READ, 1'b0, 8'h00);
        chk("in service read", 8'h20, rdata);
    endtask

    task automatic t_level();
        @(posedge mclk);
        periph_req <= 8'h40;
        settle(8);
        chk("lower level held off", 8'h00, {7'h00, u_pirc_if.irq});
        @(posedge mclk);
        periph_req <= 8'h42;
        settle(8);
        chk("higher level passes", 8'h01, {7'h00, u_pirc_if.irq});
        host_op(OP_ACK, 1'b0, 8'h00);
        chk("vector bit1", 8'h41, rdata);
        chk("in service two", 8'h22, in_service);
        host_op(OP_WRITE, 1'b0, 8'h20);
        chk("end of service first", 8'h20, in_service);
        host_op(OP_WRITE, 1'b0, 8'h20);
        chk("end of service second", 8'h00, in_service);
        @(posedge mclk);
        periph_req <= 8'h00;
        settle(8);
        chk("irq released", 8'h00, {7'h00, u_pirc_if.irq});
        host_op(OP_ACK, 1'b0, 8'h00);
        chk("spurious vector", {VEC_BASE[7:3], SPUR_ID}, rdata);
        chk("spurious no bit", 8'h00, in_service);
    endtask

    task automatic t_role();
        host_op(OP_WRITE, 1'b0, 8'h12);
        host_op(OP_READ, 1'b0, 8'h00);
        chk("status master", 8'h80, rdata);
        @(posedge mclk);
        strap_master <= 1'b0;
        settle(8);
        chk("slave strap", 8'h00, {7'h00, is_master});
        host_op(OP_READ, 1'b0, 8'h00);
        chk("status slave", 8'h00, rdata);
        // host lets go of the dual pin before the device takes it over
        @(posedge mclk);
        strap_drive <= 1'b0;
        host_op(OP_WRITE, 1'b0, 8'h1a);
        chk("buffered flag", 8'h01, {7'h00, buffered});
        host_op(OP_READ, 1'b0, 8'h00);
        chk("status buffered", 8'h40, rdata & 8'h40);
        settle(6);
        chk("buffer enable idle", 8'h01, {7'h00, u_pirc_if.master_select_or_buffer_enable});
        host_op(OP_WRITE, 1'b0, 8'h10);
        chk("buffered off", 8'h00, {7'h00, buffered});
    endtask

    task automatic bad_write(input logic cs, input logic [7:0] wd);
        @(posedge mclk);
        u_bad_if.cs_n <= cs;
        u_bad_if.port_select <= 1'b1;
        u_bad_if.host_data <= wd;
        u_bad_if.host_data_oe_n <= 1'b0;
        repeat (2) @(posedge mclk);
        u_bad_if.wr_n <= 1'b0;
        repeat (8) @(posedge mclk);
        u_bad_if.wr_n <= 1'b1;
        repeat (2) @(posedge mclk);
        u_bad_if.cs_n <= 1'b1;
        u_bad_if.host_data_oe_n <= 1'b1;
        settle(4);
    endtask

    task automatic t_select_ignored();
        @(posedge mclk);
        u_bad_if.request_lines <= 8'h01;
        bad_write(1'b1, 8'hff);
        chk("unselected write ignored", 8'h01, {7'h00, u_bad_if.irq});
        @(posedge mclk);
        u_bad_if.rd_n <= 1'b0;
        settle(8);
        chk("unselected read quiet", 8'h01, {7'h00, u_bad_if.dev_data_oe_n});
        @(posedge mclk);
        u_bad_if.rd_n <= 1'b1;
        settle(4);
        bad_write(1'b0, 8'h01);
        settle(4);
        chk("selected mask write", 8'h00, {7'h00, u_bad_if.irq});
    endtask

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            wrap_up();
        end
    end

    initial begin
        u_bad_if.cs_n = 1'b1;
        u_bad_if.rd_n = 1'b1;
        u_bad_if.wr_n = 1'b1;
        u_bad_if.ack_strobe_n = 1'b1;
        u_bad_if.port_select = 1'b0;
        u_bad_if.request_lines = 8'h00;
        u_bad_if.host_data = 8'h00;
        u_bad_if.host_data_oe_n = 1'b1;
        u_bad_if.host_mso = 1'b1;
        u_bad_if.host_mso_oe_n = 1'b1;
        repeat (8) @(posedge mclk);
        nrst <= 1'b1;
        settle(4);
        t_reset_values();
        t_priority();
        t_level();
        t_role();
        t_select_ignored();
        wrap_up();
    end
endmodule
`default_nettype wire
